// ---- pkg/rtcfc_pkg.sv ----
// Purpose: shared constants and types for the rtc flags/control block
// Assumes: 125 MHz hclk, AHB-Lite word registers
// Notes: offsets are byte addresses
package rtcfc_pkg;
	localparam logic [7:0]  ADDR_FLAGS      = 8'h00;
	localparam logic [7:0]  ADDR_TIME       = 8'h04;
	localparam logic [7:0]  ADDR_COUNTER    = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'h14;
	localparam int          BIT_READ_HOLD   = 0;
	localparam int          BIT_FREEZE      = 1;
	localparam int          BIT_CAL         = 2;
	localparam int          BIT_OSC_FAIL    = 4;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;
	localparam int          IRQ_OSC_FAIL    = 0;
	localparam int          IRQ_TICK        = 1;
	localparam int          IRQ_LOAD        = 2;
	localparam int          IRQ_W           = 3;
	localparam int          CLK_HZ          = 125_000_000;
	localparam int          OSC_CHECK_MS    = 5;
	localparam int          OSC_CHECK_CYC   = (CLK_HZ / 1000) * OSC_CHECK_MS;
	localparam int          CAL_HZ          = 512;
	localparam int          CAL_HALF_CYC    = CLK_HZ / (2 * CAL_HZ);
	localparam int          SEC_CYC         = CLK_HZ;
	localparam logic [2:0]  HTRANS_NONSEQ   = 3'h2;
	typedef enum logic [1:0] {RTCFC_BOOT, RTCFC_CHECK, RTCFC_RUN} rtcfc_state_t;
endpackage

// ---- pkg/rtcfc_tick_if.sv ----
// Purpose: carries the divided enables from the divider to the main block
// Assumes: single hclk domain
// Notes: all members are one-cycle pulses or levels on hclk
`timescale 1ns/1ps
interface rtcfc_tick_if;
	logic cal_toggle;
	logic sec_tick;
	modport src (output cal_toggle, output sec_tick);
	modport dst (input cal_toggle, input sec_tick);
endinterface

// ---- logic/rtcfc_divider.sv ----
// Purpose: enable pulses for the 512 Hz half period and the one second tick
// Assumes: hclk at 125 MHz
// Notes: sec_tick counts only while run is high
`timescale 1ns/1ps
module rtcfc_divider
	import rtcfc_pkg::*;
(
	input  wire logic   hclk,
	input  wire logic   hresetn,
	input  wire logic   run,
	rtcfc_tick_if.src   tick
);
	logic [17:0] cal_cnt_reg;
	logic [26:0] sec_cnt_reg;
	wire         cal_wrap = (cal_cnt_reg == 18'(CAL_HALF_CYC - 1));
	wire         sec_wrap = (sec_cnt_reg == 27'(SEC_CYC - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_cnt_reg <= '0;
			sec_cnt_reg <= '0;
			tick.cal_toggle <= 1'b0;
			tick.sec_tick <= 1'b0;
		end else begin
			cal_cnt_reg <= cal_wrap ? '0 : cal_cnt_reg + 18'd1;
			tick.cal_toggle <= cal_wrap;
			if (run) begin
				sec_cnt_reg <= sec_wrap ? '0 : sec_cnt_reg + 27'd1;
			end
			tick.sec_tick <= run & sec_wrap;
		end
	end
endmodule

// ---- logic/rtcfc_osc_monitor.sv ----
// Purpose: decides after the startup window whether the oscillator runs
// Assumes: osc_running already synchronised to hclk
// Notes: fail is a one-cycle pulse at the end of the window
`timescale 1ns/1ps
module rtcfc_osc_monitor
	import rtcfc_pkg::*;
#(
	parameter int       CHECK_CYC = OSC_CHECK_CYC
) (
	input  wire logic   hclk,
	input  wire logic   hresetn,
	input  wire logic   osc_enable,
	input  wire logic   osc_running,
	output logic        fail,
	output logic        done
);
	rtcfc_state_t state_reg;
	logic [19:0]  cnt_reg;
	logic         seen_reg;
	wire          last = (cnt_reg == 20'(CHECK_CYC - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= RTCFC_BOOT;
			cnt_reg   <= '0;
			seen_reg  <= 1'b0;
			fail      <= 1'b0;
			done      <= 1'b0;
		end else begin
			fail <= 1'b0;
			unique case (state_reg)
				RTCFC_BOOT: begin
					state_reg <= RTCFC_CHECK;
				end
				RTCFC_CHECK: begin
					cnt_reg  <= cnt_reg + 20'd1;
					seen_reg <= seen_reg | osc_running;
					if (last) begin
						fail      <= osc_enable & ~(seen_reg | osc_running);
						done      <= 1'b1;
						state_reg <= RTCFC_RUN;
					end
				end
				RTCFC_RUN: begin
					done <= 1'b1;
				end
				default: begin
					state_reg <= RTCFC_RUN;
				end
			endcase
		end
	end
endmodule

// ---- logic/rtcfc_top.sv ----
// Purpose: flags/control register of a real-time clock with AHB-Lite access
// Assumes: single 125 MHz clock; osc_* and event_in come from pins
// Notes: zero wait states; unmapped reads return zero, writes are dropped
`timescale 1ns/1ps
module rtcfc_top
	import rtcfc_pkg::*;
#(
	parameter int       OSC_CHECK_CYCLES = rtcfc_pkg::OSC_CHECK_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        osc_enable,
	input  wire logic        osc_running,
	input  wire logic        osc_fail_retained,
	input  wire logic        event_in,
	output logic             event_out,
	output logic             irq
);
	import rtcfc_pkg::*;

	rtcfc_tick_if tick ();

	logic              osc_meta_reg;
	logic              osc_sync_reg;
	logic              evt_meta_reg;
	logic              evt_sync_reg;
	logic              ret_meta_reg;
	logic              ret_sync_reg;
	logic              osc_fail_reg;
	logic              cal_reg;
	logic              freeze_reg;
	logic              hold_reg;
	logic              time_dirty_reg;
	logic [31:0]       counter_reg;
	logic [31:0]       time_reg;
	logic [IRQ_W-1:0]  irq_status_reg;
	logic [IRQ_W-1:0]  irq_enable_reg;
	logic              wr_pend_reg;
	logic [7:0]        wr_addr_reg;
	logic              cal_wave_reg;
	logic              mon_fail;
	logic              mon_done;
	logic              ret_caught_reg;

	rtcfc_divider u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (osc_sync_reg),
		.tick    (tick)
	);

	rtcfc_osc_monitor #(
		.CHECK_CYC (OSC_CHECK_CYCLES)
	) u_mon (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.osc_enable  (osc_enable),
		.osc_running (osc_sync_reg),
		.fail        (mon_fail),
		.done        (mon_done)
	);

	// pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			evt_meta_reg <= 1'b0;
			evt_sync_reg <= 1'b0;
			ret_meta_reg <= 1'b0;
			ret_sync_reg <= 1'b0;
		end else begin
			osc_meta_reg <= osc_running;
			osc_sync_reg <= osc_meta_reg;
			evt_meta_reg <= event_in;
			evt_sync_reg <= evt_meta_reg;
			ret_meta_reg <= osc_fail_retained;
			ret_sync_reg <= ret_meta_reg;
		end
	end

	// ahb address phase decode
	wire       addr_valid = hsel & hready & htrans[1];
	wire       wr_start   = addr_valid & hwrite;
	wire       rd_start   = addr_valid & ~hwrite;
	wire [7:0] rd_addr    = haddr[7:0];
	wire       wr_flags   = wr_pend_reg & (wr_addr_reg == ADDR_FLAGS);
	wire       wr_time    = wr_pend_reg & (wr_addr_reg == ADDR_TIME);
	wire       wr_ien     = wr_pend_reg & (wr_addr_reg == ADDR_IRQ_ENABLE);
	wire       wr_iclr    = wr_pend_reg & (wr_addr_reg == ADDR_IRQ_CLEAR);
	wire       osc_clr    = wr_flags & ~hwdata[BIT_OSC_FAIL];
	wire       osc_set    = mon_fail | (ret_sync_reg & ~ret_caught_reg);
	wire       freeze_nx  = wr_flags ? hwdata[BIT_FREEZE] : freeze_reg;
	wire       load_base  = freeze_reg & ~freeze_nx & time_dirty_reg;
	wire       refresh    = ~freeze_reg & ~hold_reg;
	wire [7:0] flags_val  = {3'h0, osc_fail_reg, 1'b0, cal_reg, freeze_reg, hold_reg};
	wire [IRQ_W-1:0] irq_evt = {load_base, tick.sec_tick, osc_set};

	function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [7:0] f,
		input logic [31:0] t, input logic [31:0] c, input logic [IRQ_W-1:0] s,
		input logic [IRQ_W-1:0] e);
		unique case (a)
			ADDR_FLAGS:      read_mux = {24'h0, f};
			ADDR_TIME:       read_mux = t;
			ADDR_COUNTER:    read_mux = c;
			ADDR_IRQ_STATUS: read_mux = {{(32-IRQ_W){1'b0}}, s};
			ADDR_IRQ_ENABLE: read_mux = {{(32-IRQ_W){1'b0}}, e};
			default:         read_mux = 32'h0;
		endcase
	endfunction

	// bus slave: always ready, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= wr_start;
			if (wr_start) begin
				wr_addr_reg <= haddr[7:0];
			end
			if (rd_start) begin
				hrdata <= read_mux(rd_addr, flags_val, time_reg, counter_reg, irq_status_reg, irq_enable_reg);
			end
		end
	end

	// flags register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_fail_reg   <= 1'b0;
			ret_caught_reg <= 1'b0;
			cal_reg        <= 1'b0;
			freeze_reg     <= 1'b0;
			hold_reg       <= 1'b0;
		end else begin
			if (mon_done) begin
				ret_caught_reg <= 1'b1;
			end
			// retained copy restores the flag across power cycles; set beats clear
			if (osc_set) begin
				osc_fail_reg <= 1'b1;
			end else if (osc_clr) begin
				osc_fail_reg <= 1'b0;
			end
			if (wr_flags) begin
				cal_reg    <= hwdata[BIT_CAL];
				freeze_reg <= hwdata[BIT_FREEZE];
				hold_reg   <= hwdata[BIT_READ_HOLD];
			end
		end
	end

	// timekeeping counter and visible time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_reg    <= 32'h0;
			time_reg       <= 32'h0;
			time_dirty_reg <= 1'b0;
		end else begin
			if (load_base) begin
				counter_reg <= time_reg;
			end else if (tick.sec_tick) begin
				counter_reg <= counter_reg + 32'h1;
			end
			if (wr_time & freeze_reg) begin
				time_reg <= hwdata;
			end else if (refresh) begin
				time_reg <= counter_reg;
			end
			if (wr_time & freeze_reg) begin
				time_dirty_reg <= 1'b1;
			end else if (~freeze_nx) begin
				time_dirty_reg <= 1'b0;
			end
		end
	end

	// event pin and interrupts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_wave_reg   <= 1'b0;
			event_out      <= 1'b0;
			irq_status_reg <= '0;
			irq_enable_reg <= '0;
			irq            <= 1'b0;
		end else begin
			if (!cal_reg) begin
				cal_wave_reg <= 1'b0;
			end else if (tick.cal_toggle) begin
				cal_wave_reg <= ~cal_wave_reg;
			end
			event_out <= cal_reg ? cal_wave_reg : evt_sync_reg;
			if (wr_ien) begin
				irq_enable_reg <= hwdata[IRQ_W-1:0];
			end
			irq_status_reg <= irq_evt | (irq_status_reg & ~(wr_iclr ? hwdata[IRQ_W-1:0] : '0));
			irq <= |(irq_status_reg & irq_enable_reg);
		end
	end
endmodule

// ---- verif/rtcfc_props.sv ----
// Purpose: port assertions for rtcfc_top
// Assumes: single hclk domain, zero wait states
// Notes: flag and enable shadows follow bus writes
`timescale 1ns/1ps
module rtcfc_props
	import rtcfc_pkg::*;
#(
	parameter int OSC_CHECK_CYCLES = 50
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        event_in,
	input wire logic        event_out,
	input wire logic        irq
);
	logic             rd, wr, of;
	logic [7:0]       a;
	logic [3:0]       sn;
	logic [2:0]       f, cnt;
	logic [IRQ_W-1:0] en;
	wire              take = hsel & hready & htrans[1];
	wire              fa   = a == ADDR_FLAGS;
	wire              fr   = rd & fa;
	wire              um   = rd & ((a > ADDR_IRQ_CLEAR) | (a[1:0] != 2'h0));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd  <= 1'b0;
			wr  <= 1'b0;
			a   <= 8'h00;
			sn  <= 4'h0;
			f   <= 3'h0;
			of  <= 1'b0;
			en  <= '0;
			cnt <= 3'h0;
		end else begin
			rd  <= take & !hwrite;
			wr  <= take & hwrite;
			a   <= take ? haddr[7:0] : a;
			sn  <= {of, f};
			cnt <= f[BIT_CAL] ? 3'h0 : cnt + {2'h0, cnt != 3'h4};
			if (wr & fa)
				f <= hwdata[2:0];
			if (wr & fa & !hwdata[BIT_OSC_FAIL])
				of <= 1'b0;
			else if (fr & hrdata[BIT_OSC_FAIL])
				of <= 1'b1;
			if (wr & (a == ADDR_IRQ_ENABLE))
				en <= hwdata[IRQ_W-1:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_high_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp) else $error("hresp not okay");
	unmapped_zero_a: assert property (um |-> hrdata == 32'h0) else $error("unmapped read not zero");
	flags_upper_a: assert property (fr |-> hrdata[31:5] == 27'h0 && !hrdata[3]) else $error("flags upper bits set");
	ctrl_bits_a: assert property (fr |-> hrdata[2:0] == sn[2:0]) else $error("control bits differ");
	osc_kept_a: assert property (fr && sn[3] |-> hrdata[BIT_OSC_FAIL]) else $error("fail flag lost");
	event_pass_a: assert property (cnt == 3'h4 |-> event_out == $past(event_in, 3)) else $error("event path");
	irq_masked_a: assert property (en == '0 && $past(en) == '0 |-> !irq) else $error("irq while masked");
	cover property (fr && hrdata[BIT_OSC_FAIL]);
	cover property (f[BIT_CAL]);
	cover property (irq);
endmodule
bind rtcfc_top rtcfc_props #(.OSC_CHECK_CYCLES(OSC_CHECK_CYCLES)) u_props (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .event_in, .event_out, .irq);

// ---- verif/rtc_flags_control_bench.sv ----
// Purpose: self-checking bench for rtcfc_top
// Assumes: zero-wait AHB-Lite slave, short oscillator window
// Notes: flags kept in an int model, event path in a queue
`timescale 1ns/1ps
module rtc_flags_control_bench;
	import rtcfc_pkg::*;
	localparam int CHK = 50;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, b, eo;
	logic        osc_enable, osc_running, osc_fail_retained, event_in, event_out, irq;
	logic [31:0] haddr, hwdata, hrdata, rv, tv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          miscompares, n_tests, seed, mf, nch, i;
	logic        eq[$];
	assign hready = hreadyout;
	rtcfc_top #(.OSC_CHECK_CYCLES(CHK)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .osc_enable, .osc_running, .osc_fail_retained,
		.event_in, .event_out, .irq);
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task results;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wt;
		int k;
		k = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			k++;
			if (k > 100) begin
				miscompares++;
				results;
			end
			@(posedge hclk);
		end
	endtask
	task xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, ad};
		htrans <= HTRANS_NONSEQ[1:0];
		hwrite <= w;
		wt;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		rv = hrdata;
	endtask
	task wf(input logic [7:0] d);
		xf(1'b1, ADDR_FLAGS, {24'h0, d});
		mf[2:0] = d[2:0];
		if (!d[BIT_OSC_FAIL])
			mf[BIT_OSC_FAIL] = 0;
	endtask
	task rf;
		xf(1'b0, ADDR_FLAGS, 32'h0);
		chk(rv, mf);
	endtask
	task rst;
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// cal on: count output edges; cal off: output is input three cycles late
	task ev(input int n);
		nch = 0;
		eq.delete();
		eo = event_out;
		for (i = 0; i < n; i++) begin
			@(posedge hclk);
			b = $random(seed);
			event_in <= b;
			eq.push_back(b);
			#1;
			if (mf[BIT_CAL])
				nch += int'(event_out !== eo);
			else if (eq.size() > 3)
				chk({31'h0, event_out}, {31'h0, eq[eq.size()-4]});
			eo = event_out;
		end
		if (mf[BIT_CAL])
			chk({31'h0, nch < 2}, 32'h1);
	endtask
	initial begin
		seed = 32'h188b;
		{hresetn, hsel, hwrite, osc_running, osc_fail_retained, event_in} = 6'h0;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		osc_enable = 1'b1;
		mf = 0;
		rst;
		rf;
		repeat (CHK + 10) @(posedge hclk);
		mf = 32'h10;
		rf;
		xf(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rv, 32'h1);
		chk({31'h0, irq}, 32'h0);
		xf(1'b1, ADDR_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		xf(1'b1, ADDR_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		wf(8'h10);
		rf;
		wf(8'h00);
		rf;
		wf(8'h04);
		rf;
		ev(100);
		wf(8'h00);
		ev(40);
		wf(8'h02);
		tv = $random(seed);
		xf(1'b1, ADDR_TIME, tv);
		repeat (5) @(posedge hclk);
		xf(1'b0, ADDR_TIME, 32'h0);
		chk(rv, tv);
		wf(8'h00);
		repeat (2) @(posedge hclk);
		xf(1'b0, ADDR_COUNTER, 32'h0);
		chk(rv, tv);
		wf(8'h01);
		rf;
		xf(1'b1, 8'h20, 32'h5a5a5a5a);
		xf(1'b0, 8'h20, 32'h0);
		chk(rv, 32'h0);
		osc_enable <= 1'b0;
		osc_fail_retained <= 1'b1;
		mf = 32'h10;
		rst;
		repeat (10) @(posedge hclk);
		rf;
		results;
	end
endmodule
